// ===== hw/i2cefe_top.sv
// i2cefe_top: two-wire target front end of an 8 k x 8 nonvolatile memory with ecc
// and a lockable 32-byte identification page.
// assumes an external pull-up on the data wire and a bus controller that makes scl.
// Summary of operation
// [R01] array of 8 k bytes, 256 pages of 32, each byte writable
// [R02] stored array bytes carry a correcting code, checked on every read
// [R03] separate 32-byte identification page, permanently lockable to read-only; the lock flag here is cleared by reset
// [R04] the bus clock times both sampling and driving of the data wire
// [R05] data wire is only pulled low or released, never driven high
// [R06] strap pins compared with bits 3..1 of the select byte
// [R07] unconnected strap pins count as zero
// [R08] write inhibit high blocks every write to the memory
// [R09] write inhibit low or floating lets writes through
// [R10] under inhibit, select and address bytes acked, data bytes not
// [R11] target only: never makes clocks, start or stop
// [R12] start is data falling while clock is high
// [R13] controller sends a start before every transfer
// [R14] start watched always, except during the internal write cycle
// [R15] stop is data rising while clock is high
// [R16] stop ends the exchange and waits for a new start
// [R17] stop after a write launches the internal write cycle
// [R18] data sampled on each rising clock edge
// [R19] controller changes data only while the clock is low
// [R20] receiver pulls data low on the ninth clock to acknowledge
// [R21] answer only type codes 1010b (array) and 1011b (identification page)
// [R22] last select bit: 1 read, 0 write
// [R23] write cycle length is a parameter; bus ignored throughout it
`default_nettype none

module i2cefe_top
  import i2cefe_pkg::*;
#(
  parameter int unsigned WR_CYC = WR_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_b_o,
  input wire logic [2:0] chip_select_strap_pins_i,
  input wire logic write_inhibit_input_i,
  output logic write_busy_o
);

  // pin synchronisers, plus one history stage for edges
  logic [5:0] sync1_reg, sync2_reg;
  logic [1:0] hist_reg;
  logic scl_s, sda_s, wi_s;
  logic [2:0] strap_s;
  logic scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
      hist_reg <= SYNC_RST[1:0];
    end else begin
      sync1_reg <= {write_inhibit_input_i, chip_select_strap_pins_i, sda_i, scl_i};
      sync2_reg <= sync1_reg;
      hist_reg <= sync2_reg[1:0];
    end
  end

  // [R07] floating straps and inhibit read low via board pull-downs
  assign {wi_s, strap_s, sda_s, scl_s} = sync2_reg;
  // [R04] clock edges found by sampling
  assign scl_rise = scl_s && !hist_reg[0];
  assign scl_fall = !scl_s && hist_reg[0];
  // [R12] data falls while clock high
  assign start_det = scl_s && hist_reg[0] && hist_reg[1] && !sda_s;
  // [R15] data rises while clock high
  assign stop_det = scl_s && hist_reg[0] && !hist_reg[1] && sda_s;

  // [R01] byte array, [R02] each location holds a codeword
  i2cefe_code_t mem_arr [ARRAY_BYTES];
  // [R03] identification page
  logic [7:0] mem_id [PAGE_BYTES];
  logic [7:0] latch [PAGE_BYTES];

  i2cefe_state_t state_reg, state_next, after_reg, after_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next, tx_reg, tx_next, hi_reg, hi_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [PAGE_BYTES-1:0] mask_reg, mask_next;
  logic [TIMER_W-1:0] timer_reg, timer_next;
  logic [OFS_W:0] cidx_reg, cidx_next;
  logic oe_b_reg, oe_b_next, ack_reg, ack_next, rw_reg, rw_next;
  logic idsel_reg, idsel_next, lockop_reg, lockop_next;
  logic pend_reg, pend_next, lockreq_reg, lockreq_next, lock_reg, lock_next;
  logic busy_reg, push, ok, commit_we;
  logic [7:0] byte_v, rdata;
  i2cefe_wr_t in_w, out_w;
  logic buf_in_ready, buf_out_valid, buf_out_ready, drain;

  assign byte_v = {shift_reg[6:0], sda_s};
  // [R02] single-bit errors corrected on the way out
  assign rdata = idsel_reg ? mem_id[addr_reg[OFS_W-1:0]] : i2cefe_dec(mem_arr[addr_reg]);
  assign in_w = '{ofs: addr_reg[OFS_W-1:0], data: byte_v};
  // drain stalls while the page latch is being committed
  assign buf_out_ready = !(state_reg == ST_WCYCLE && cidx_reg != '0);
  assign drain = buf_out_valid && buf_out_ready;
  assign commit_we = state_reg == ST_WCYCLE && timer_reg == '0 && !buf_out_valid
    && cidx_reg != (OFS_W + 1)'(PAGE_BYTES) && mask_reg[cidx_reg[OFS_W-1:0]];

  i2cefe_buf #(
    .W($bits(i2cefe_wr_t)),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(push),
    .in_ready_o(buf_in_ready),
    .in_data_i(in_w),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_out_ready),
    .out_data_o(out_w)
  );

  always_comb begin
    state_next = state_reg;
    after_next = after_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    hi_next = hi_reg;
    addr_next = addr_reg;
    mask_next = mask_reg;
    timer_next = timer_reg;
    cidx_next = cidx_reg;
    oe_b_next = oe_b_reg;
    ack_next = ack_reg;
    rw_next = rw_reg;
    idsel_next = idsel_reg;
    lockop_next = lockop_reg;
    pend_next = pend_reg;
    lockreq_next = lockreq_reg;
    lock_next = lock_reg;
    push = 1'b0;
    ok = 1'b0;
    if (drain) begin
      mask_next[out_w.ofs] = 1'b1;
    end
    if (state_reg == ST_WCYCLE) begin
      // [R14] [R23] bus ignored, wire released
      oe_b_next = 1'b1;
      if (timer_reg != '0) begin
        timer_next = timer_reg - 1'b1;
        if (timer_reg == TIMER_W'(1)) begin
          state_next = ST_IDLE;
        end
      end else if (!buf_out_valid) begin
        if (cidx_reg == (OFS_W + 1)'(PAGE_BYTES)) begin
          // [R23] hold off the bus for the programmed time
          timer_next = TIMER_W'(WR_CYC);
          // [R03] lock is one way
          lock_next = lock_reg | lockreq_reg;
          lockreq_next = 1'b0;
          pend_next = 1'b0;
          mask_next = '0;
        end else begin
          cidx_next = cidx_reg + 1'b1;
        end
      end
    end else if (start_det) begin
      // [R12] [R13] every transfer opens here
      state_next = ST_DEVSEL;
      bit_next = '0;
      oe_b_next = 1'b1;
      pend_next = 1'b0;
      lockreq_next = 1'b0;
    end else if (stop_det) begin
      // [R16] [R17] stop ends the exchange; a write goes to the cells
      state_next = pend_reg ? ST_WCYCLE : ST_IDLE;
      bit_next = '0;
      oe_b_next = 1'b1;
      cidx_next = '0;
    end else if (state_reg == ST_RDATA) begin
      if (scl_fall) begin
        // [R04] [R05] [R19] output bits change only while clock is low
        if (bit_reg == 4'h9) begin
          tx_next = rdata;
          oe_b_next = rdata[7];
          bit_next = '0;
        end else if (bit_reg == 4'h8) begin
          oe_b_next = 1'b1;
        end else begin
          oe_b_next = tx_reg[7];
        end
      end else if (scl_rise) begin
        if (bit_reg == 4'h8) begin
          // [R20] controller acks to continue, otherwise stand by
          if (!sda_s) begin
            bit_next = 4'h9;
            addr_next = addr_reg + 1'b1;
          end else begin
            state_next = ST_IDLE;
          end
        end else begin
          tx_next = {tx_reg[6:0], 1'b0};
          bit_next = bit_reg + 1'b1;
        end
      end
    end else if (state_reg != ST_IDLE) begin
      if (scl_rise) begin
        if (bit_reg == 4'h8) begin
          bit_next = 4'h9;
        end else if (bit_reg != 4'h9) begin
          // [R18] [R19] sample on the rising edge
          shift_next = byte_v;
          bit_next = bit_reg + 1'b1;
          if (bit_reg == 4'h7) begin
            unique case (state_reg)
              ST_DEVSEL: begin
                // [R06] [R21] type and strap match or drop off the bus
                ok = (byte_v[7:SEL_TYPE_LSB] == TYPE_ARRAY
                  || byte_v[7:SEL_TYPE_LSB] == TYPE_IDPAGE)
                  && byte_v[SEL_CE_LSB+:3] == strap_s;
                ack_next = ok;
                if (!ok) begin
                  state_next = ST_IDLE;
                end
                // [R22] direction bit
                rw_next = byte_v[SEL_DIR_BIT];
                idsel_next = byte_v[SEL_IDP_BIT];
                after_next = byte_v[SEL_DIR_BIT] ? ST_RDATA : ST_ADDR_HI;
                if (ok && !byte_v[SEL_DIR_BIT]) begin
                  mask_next = '0;
                end
              end
              ST_ADDR_HI: begin
                // [R10] address bytes acked regardless of inhibit
                ack_next = 1'b1;
                hi_next = byte_v;
                after_next = ST_ADDR_LO;
              end
              ST_ADDR_LO: begin
                ack_next = 1'b1;
                addr_next = {hi_reg[ADDR_W-9:0], byte_v};
                lockop_next = idsel_reg && hi_reg[HI_LOCK_BIT];
                after_next = ST_WDATA;
              end
              ST_WDATA: begin
                // [R08] [R09] [R10] data taken only without inhibit
                ok = !wi_s && !(idsel_reg && lock_reg) && (lockop_reg || buf_in_ready);
                ack_next = ok;
                after_next = ST_WDATA;
                if (ok) begin
                  pend_next = 1'b1;
                  if (lockop_reg) begin
                    lockreq_next = 1'b1;
                  end else begin
                    push = 1'b1;
                    addr_next[OFS_W-1:0] = addr_reg[OFS_W-1:0] + 1'b1;
                  end
                end
              end
              ST_IDLE, ST_RDATA, ST_WCYCLE: begin
              end
            endcase
          end
        end
      end else if (scl_fall) begin
        if (bit_reg == 4'h8 && ack_reg) begin
          // [R05] [R20] acknowledge by pulling low
          oe_b_next = 1'b0;
        end else if (bit_reg == 4'h9) begin
          oe_b_next = 1'b1;
          bit_next = '0;
          state_next = after_reg;
          if (after_reg == ST_RDATA) begin
            tx_next = rdata;
            oe_b_next = rdata[7];
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
      after_reg <= ST_IDLE;
      bit_reg <= '0;
      shift_reg <= '0;
      tx_reg <= '0;
      hi_reg <= '0;
      addr_reg <= '0;
      mask_reg <= '0;
      timer_reg <= '0;
      cidx_reg <= '0;
      oe_b_reg <= 1'b1;
      ack_reg <= 1'b0;
      rw_reg <= 1'b0;
      idsel_reg <= 1'b0;
      lockop_reg <= 1'b0;
      pend_reg <= 1'b0;
      lockreq_reg <= 1'b0;
      lock_reg <= LOCK_RST;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      after_reg <= after_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      hi_reg <= hi_next;
      addr_reg <= addr_next;
      mask_reg <= mask_next;
      timer_reg <= timer_next;
      cidx_reg <= cidx_next;
      oe_b_reg <= oe_b_next;
      ack_reg <= ack_next;
      rw_reg <= rw_next;
      idsel_reg <= idsel_next;
      lockop_reg <= lockop_next;
      pend_reg <= pend_next;
      lockreq_reg <= lockreq_next;
      lock_reg <= lock_next;
      busy_reg <= state_next == ST_WCYCLE;
    end
  end

  // cells are not reset: contents survive a reset as they would a power cycle
  always_ff @(posedge mclk_i) begin
    if (drain) begin
      latch[out_w.ofs] <= out_w.data;
    end
    if (commit_we) begin
      // [R01] [R03] one byte per cycle, only those written
      if (idsel_reg) begin
        mem_id[cidx_reg[OFS_W-1:0]] <= latch[cidx_reg[OFS_W-1:0]];
      end else begin
        mem_arr[{addr_reg[ADDR_W-1:OFS_W], cidx_reg[OFS_W-1:0]}] <=
          i2cefe_enc(latch[cidx_reg[OFS_W-1:0]]);
      end
    end
  end

  // [R05] [R11] only ever a low level; no clock or condition is made here
  assign sda_o = 1'b0;
  assign sda_oe_b_o = oe_b_reg;
  assign write_busy_o = busy_reg;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  logic rx_st;
  assign rx_st = state_reg inside {ST_DEVSEL, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA};

  wcycle_quiet_a: assert property (state_reg == ST_WCYCLE |-> sda_oe_b_o) // [R23]
    else $error("data wire driven during write cycle");
  wcycle_deaf_a: assert property (state_reg == ST_WCYCLE && timer_reg > TIMER_W'(1)
    && start_det |=> state_reg == ST_WCYCLE) // [R14]
    else $error("start seen during write cycle");
  start_devsel_a: assert property (start_det && state_reg != ST_WCYCLE
    |=> state_reg == ST_DEVSEL && bit_reg == 4'h0 && sda_oe_b_o) // [R12]
    else $error("start did not open a select phase");
  stop_idle_a: assert property (stop_det && state_reg != ST_WCYCLE && !pend_reg
    |=> state_reg == ST_IDLE) // [R16]
    else $error("stop did not end the exchange");
  stop_launch_a: assert property (stop_det && state_reg != ST_WCYCLE && pend_reg
    |=> state_reg == ST_WCYCLE ##0 write_busy_o) // [R17]
    else $error("stop after write did not start write cycle");
  rise_sample_a: assert property (rx_st && scl_rise && bit_reg < 4'h8 && !start_det
    && !stop_det |=> shift_reg[0] == $past(sda_s) && bit_reg == $past(bit_reg) + 4'h1) // [R18]
    else $error("data not sampled on clock rise");
  strap_miss_a: assert property (state_reg == ST_DEVSEL && scl_rise && bit_reg == 4'h7
    && !start_det && !stop_det && byte_v[3:1] != strap_s |=> state_reg == ST_IDLE) // [R06]
    else $error("foreign select byte not ignored");
  type_miss_a: assert property (state_reg == ST_DEVSEL && scl_rise && bit_reg == 4'h7
    && !start_det && !stop_det && byte_v[7:5] != 3'h5 |=> !ack_reg) // [R21]
    else $error("unknown type code acknowledged");
  inhibit_nack_a: assert property (state_reg == ST_WDATA && scl_rise && bit_reg == 4'h7
    && !start_det && !stop_det && wi_s |=> !ack_reg && !pend_reg) // [R10]
    else $error("data byte acknowledged under inhibit");
  inhibit_block_a: assert property (wi_s |-> !push) // [R08]
    else $error("write queued under inhibit");
  ack_pull_a: assert property (rx_st && bit_reg == 4'h8 && ack_reg && scl_fall
    && !start_det && !stop_det |=> !sda_oe_b_o ##1 !sda_oe_b_o) // [R20]
    else $error("acknowledge not driven");

  devsel_ack_c: cover property (state_reg == ST_DEVSEL ##1 state_reg == ST_ADDR_HI);
  read_byte_c: cover property (state_reg == ST_RDATA && scl_rise && bit_reg == 4'h8 && !sda_s);
  wcycle_c: cover property (state_reg == ST_WCYCLE ##1 timer_reg != '0);
  lock_c: cover property (!lock_reg ##1 lock_reg);

endmodule : i2cefe_top

`default_nettype wire

// ===== hw/i2cefe_pkg.sv
// i2cefe_pkg: constants, types and the ecc code of the two-wire memory front end.
// assumes a single 200 MHz system clock; every bus pin is asynchronous to it.
`default_nettype none

package i2cefe_pkg;

  localparam int unsigned CLK_FREQ_KHZ = 200000;
  // internal nonvolatile write cycle, in milliseconds
  localparam int unsigned WR_TIME_MS = 4;
  localparam int unsigned WR_CYCLES = WR_TIME_MS * CLK_FREQ_KHZ;
  localparam int TIMER_W = 20;

  localparam int ADDR_W = 13;
  localparam int OFS_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int PAGES = 256;
  localparam int ARRAY_BYTES = PAGES * PAGE_BYTES;
  localparam int BUF_DEPTH = 2;

  // device select byte layout
  localparam logic [3:0] TYPE_ARRAY = 4'ha;
  localparam logic [3:0] TYPE_IDPAGE = 4'hb;
  localparam int SEL_DIR_BIT = 0;
  localparam int SEL_CE_LSB = 1;
  localparam int SEL_IDP_BIT = 4;
  localparam int SEL_TYPE_LSB = 4;
  // bit of the high address byte that selects the lock operation
  localparam int HI_LOCK_BIT = 2;

  // reset values
  localparam logic [5:0] SYNC_RST = 6'h03;
  localparam logic LOCK_RST = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEVSEL = 3'h1,
    ST_ADDR_HI = 3'h2,
    ST_ADDR_LO = 3'h3,
    ST_WDATA = 3'h4,
    ST_RDATA = 3'h5,
    ST_WCYCLE = 3'h6
  } i2cefe_state_t;

  typedef struct packed {
    logic [OFS_W-1:0] ofs;
    logic [7:0] data;
  } i2cefe_wr_t;

  // hamming (12,8): {p3, p2, p1, p0, data}
  typedef logic [11:0] i2cefe_code_t;

  function automatic i2cefe_code_t i2cefe_enc(input logic [7:0] d);
    logic [3:0] p;
    p[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
    p[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
    p[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
    p[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
    return {p, d};
  endfunction : i2cefe_enc

  // corrects any single flipped bit, data or check
  function automatic logic [7:0] i2cefe_dec(input i2cefe_code_t c);
    logic [3:0] s;
    logic [7:0] d;
    i2cefe_code_t e;
    d = c[7:0];
    // a function result cannot be sliced directly, so it goes through a variable
    e = i2cefe_enc(d);
    s = c[11:8] ^ e[11:8];
    unique case (s)
      4'h3: d[0] = ~d[0];
      4'h5: d[1] = ~d[1];
      4'h6: d[2] = ~d[2];
      4'h7: d[3] = ~d[3];
      4'h9: d[4] = ~d[4];
      4'ha: d[5] = ~d[5];
      4'hb: d[6] = ~d[6];
      4'hc: d[7] = ~d[7];
      default: d = d;
    endcase
    return d;
  endfunction : i2cefe_dec

endpackage : i2cefe_pkg

`default_nettype wire

// ===== hw/i2cefe_buf.sv
// i2cefe_buf: small valid/ready buffer for received write bytes.
// assumes both sides on mclk_i; full shows as in_ready_o low.
`default_nettype none

module i2cefe_buf #(
  parameter int W = 13,
  parameter int DEPTH = 2
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic do_in, do_out;

  assign in_ready_o = cnt_reg != (AW + 1)'(DEPTH);
  assign out_valid_o = cnt_reg != '0;
  assign out_data_o = mem[rp_reg];
  assign do_in = in_valid_i && in_ready_o;
  assign do_out = out_valid_o && out_ready_i;

  always_comb begin
    wp_next = wp_reg;
    rp_next = rp_reg;
    if (do_in) begin
      wp_next = (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
    end
    if (do_out) begin
      rp_next = (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
    end
    cnt_next = cnt_reg + (AW + 1)'(do_in) - (AW + 1)'(do_out);
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (do_in) begin
      mem[wp_reg] <= in_data_i;
    end
  end

endmodule : i2cefe_buf

`default_nettype wire

// ===== verif/i2cefe_bus_master.sv
// i2cefe_bus_master: behavioural two-wire bus controller that drives the memory front end.
// assumes the bench resolves the data wire with a pull-up and hands the level back on sda_i.
`default_nettype none

module i2cefe_bus_master (
  input wire logic mclk_i,
  input wire logic sda_i,
  output var logic scl_o,
  output var logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idles released and the clock stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : wt

  // data moves only while clock low; sampled mid high phase
  task automatic clk_bit(input logic b, output logic s);
    sda_o = b;
    wt(8);
    scl_o = 1'b1;
    wt(8);
    s = sda_i;
    wt(8);
    scl_o = 1'b0;
    wt(8);
  endtask : clk_bit

  // start opens every transfer, also a repeated one
  task automatic start();
    sda_o = 1'b1;
    wt(8);
    scl_o = 1'b1;
    wt(8);
    sda_o = 1'b0;
    wt(8);
    scl_o = 1'b0;
    wt(8);
  endtask : start

  task automatic stop();
    sda_o = 1'b0;
    wt(8);
    scl_o = 1'b1;
    wt(8);
    sda_o = 1'b1;
    wt(8);
  endtask : stop

  // released in the ninth clock so the target can acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : wbyte

  // controller pulls low to ask for more, releases on the last byte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(last, s);
    sda_o = 1'b1;
  endtask : rbyte

endmodule : i2cefe_bus_master

`default_nettype wire

// ===== verif/tb_i2c_eeprom_slave_front_end.sv
// tb_i2c_eeprom_slave_front_end: self-checking bench of the two-wire memory front end.
// assumes the bus controller model beside it; expected bytes kept in an associative array.
`default_nettype none

`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_i2c_eeprom_slave_front_end
  import i2cefe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // short write cycle keeps the run small but outlasts one select byte
  localparam int unsigned WRC = 400;
  localparam int LIMIT = 80000;

  logic mclk, rst_b, scl, sda_m, sda_w, sda_o, sda_oe_b, inh, busy;
  logic [2:0] strap;
  logic [7:0] mem [int];
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;

  assign sda_w = sda_m & sda_oe_b;

  i2cefe_top #(.WR_CYC(WRC)) u_dut (
    .mclk_i(mclk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_b_o(sda_oe_b), .chip_select_strap_pins_i(strap),
    .write_inhibit_input_i(inh), .write_busy_o(busy)
  );

  i2cefe_bus_master u_mst (.mclk_i(mclk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  always @(posedge mclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, cyc, 0);
      final_report();
    end
  end

  task automatic sel_addr(input logic [12:0] a);
    logic ak;
    u_mst.start();
    u_mst.wbyte({TYPE_ARRAY, strap, 1'b0}, ak);
    `CHK(ak, 1'b1)
    u_mst.wbyte({3'h0, a[12:8]}, ak);
    `CHK(ak, 1'b1)
    u_mst.wbyte(a[7:0], ak);
    `CHK(ak, 1'b1)
  endtask : sel_addr

  task automatic wr_seq(input logic [12:0] a, input int n, input logic dack);
    logic ak;
    logic [7:0] d;
    logic [12:0] ix;
    sel_addr(a);
    for (int i = 0; i < n; i++) begin
      d = $urandom;
      ix = {a[12:5], a[4:0] + i[4:0]};
      u_mst.wbyte(d, ak);
      `CHK(ak, dack)
      if (dack) begin
        mem[int'(ix)] = d;
      end
    end
    u_mst.stop();
  endtask : wr_seq

  task automatic rd_seq(input logic [12:0] a, input int n);
    logic ak;
    logic [7:0] d;
    sel_addr(a);
    u_mst.start();
    u_mst.wbyte({TYPE_ARRAY, strap, 1'b1}, ak);
    `CHK(ak, 1'b1)
    for (int i = 0; i < n; i++) begin
      u_mst.rbyte(i == n - 1, d);
      `CHK(d, mem[int'(a + 13'(i))])
    end
    u_mst.stop();
    `CHK(sda_o, 1'b0)
  endtask : rd_seq

  // checks the busy window, then that it ends within a bounded wait
  task automatic wait_wc(input logic exp_busy);
    logic ak;
    `CHK(busy, exp_busy)
    if (exp_busy) begin
      u_mst.start();
      u_mst.wbyte({TYPE_ARRAY, strap, 1'b0}, ak);
      `CHK(ak, 1'b0)
      u_mst.stop();
    end
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) begin
      @(negedge mclk);
    end
    `CHK(busy, 1'b0)
  endtask : wait_wc

  initial begin
    logic ak;
    logic [12:0] a;
    int n;
    void'($urandom(32'h646043a9));
    rst_b = 1'b0;
    inh = 1'b0;
    strap = 3'($urandom);
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    repeat (8) @(negedge mclk);
    for (int t = 0; t < 16; t++) begin
      u_mst.start();
      u_mst.wbyte({t[3:0], strap, 1'b0}, ak);
      `CHK(ak, (t == 10 || t == 11))
      u_mst.stop();
    end
    $display("test type_codes done");
    for (int k = 0; k < 8; k++) begin
      u_mst.start();
      u_mst.wbyte({TYPE_ARRAY, k[2:0], 1'b0}, ak);
      `CHK(ak, (k[2:0] == strap))
      u_mst.stop();
    end
    strap = 3'h0;
    u_mst.start();
    u_mst.wbyte({TYPE_ARRAY, 3'h0, 1'b0}, ak);
    `CHK(ak, 1'b1)
    u_mst.stop();
    $display("test strap_match done");
    // page end: third byte wraps to the start of the same page
    a = {8'($urandom), 5'h1e};
    wr_seq(a, 3, 1'b1);
    wait_wc(1'b1);
    rd_seq(a, 2);
    rd_seq({a[12:5], 5'h00}, 1);
    $display("test page_wrap done");
    inh = 1'b1;
    wr_seq(a, 1, 1'b0);
    wait_wc(1'b0);
    inh = 1'b0;
    rd_seq(a, 1);
    $display("test inhibit done");
    // address only, then stop: nothing to commit
    wr_seq(a, 0, 1'b1);
    wait_wc(1'b0);
    $display("test no_data done");
    for (int r = 0; r < 3; r++) begin
      a = 13'($urandom);
      n = 1 + ($urandom % 4);
      wr_seq(a, n, 1'b1);
      wait_wc(1'b1);
      rd_seq(a, 1);
    end
    $display("test random_writes done");
    final_report();
  end

endmodule : tb_i2c_eeprom_slave_front_end

`undef CHK

`default_nettype wire
